// ===== logic/chip_reset_pkg.sv
package chip_reset_pkg;

    // Clock and timing
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned CLK_PERIOD_NS    = 5;
    localparam int unsigned POR_TIME_MS      = 22;
    localparam int unsigned POR_CYCLES_DFLT  = POR_TIME_MS * CLK_MHZ * 1000;
    localparam int unsigned SOFT_TIME_NS     = 2000;
    localparam int unsigned SOFT_CYCLES_DFLT = SOFT_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned LITE_CYCLES_DFLT = 16;
    localparam int unsigned USBR_CYCLES_DFLT = 16;
    localparam int unsigned ACK_WAIT_DFLT    = 256;
    localparam int unsigned CNT_W            = 32;

    // Register map
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;
    localparam logic [7:0]  OFS_HARDWARE_CONFIG_REG    = 8'h00;
    localparam logic [7:0]  OFS_POWER_MGMT_CONTROL_REG  = 8'h04;
    localparam logic [7:0]  OFS_STRAP     = 8'h08;

    // Field positions
    localparam int unsigned BIT_SOFT      = 0;
    localparam int unsigned BIT_LITE      = 1;
    localparam int unsigned USR_LSB       = 8;
    localparam int unsigned NOT_AFFECTED_BY_SOFT_RESET_LSB      = 16;
    localparam int unsigned FLD_W         = 8;
    localparam int unsigned BIT_READY     = 0;
    localparam int unsigned BIT_PHY_PD    = 1;

    // Reset values
    localparam logic [7:0]  USR_RST       = 8'h00;
    localparam logic [7:0]  NOT_AFFECTED_BY_SOFT_RESET_RST      = 8'h00;

    // Register bus request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    // Internal reset domains, active high
    typedef struct packed {
        logic pll;
        logic usb_ctrl;
        logic chip_core;
        logic test_port;
    } rst_domains_t;

    // Sequencer states
    typedef enum logic [7:0] {
        ST_POR      = 8'h01,
        ST_PIN      = 8'h02,
        ST_SOFT_ACK = 8'h04,
        ST_SOFT     = 8'h08,
        ST_LITE     = 8'h10,
        ST_USB      = 8'h20,
        ST_LOAD     = 8'h40,
        ST_READY    = 8'h80
    } seq_state_t;

endpackage

// ===== logic/chip_reset_and_strap_control.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// R01: Power-on holds internal reset about 22 ms
// R02: Power-on reloads full configuration memory
// R03: Power-on puts Ethernet PHY in power-down
// R04: Low reset pin starts hardware reset
// R05: Ready reads 0 during pin reset
// R06: Reset pin weakly pulled high
// R07: Pin reset puts Ethernet PHY in power-down
// R08: Lite reset spares USB side, PLL
// R09: Lite reset: no reload, stays configured
// R10: Host resets endpoint pipes after lite
// R11: Soft bit self-clears after about 2 us
// R12: Soft reset keeps not-affected bits
// R13: Soft reset reloads memory, powers down PHY
// R14: Soft reset: ack OUT, then disconnect
// R15: USB reset follows power, pin, soft
// R16: Ready low until memory load finishes
// R17: USB reset reloads MAC only, PHY down
// R18: Test reset clears only test port
// R19: Straps tri-stated in reset, latched after
// R20: Straps latched only on power, pin
// R21: Board never drives straps, uses resistors
// R22: Reset release synchronous to core clock
module chip_reset_and_strap_control
    import chip_reset_pkg::*;
#(
    parameter int unsigned POR_CYCLES  = POR_CYCLES_DFLT,
    parameter int unsigned SOFT_CYCLES = SOFT_CYCLES_DFLT,
    parameter int unsigned LITE_CYCLES = LITE_CYCLES_DFLT,
    parameter int unsigned USBR_CYCLES = USBR_CYCLES_DFLT,
    parameter int unsigned ACK_WAIT    = ACK_WAIT_DFLT,
    parameter int unsigned STRAP_W     = 4
) (
    // Clock and power-on reset
    input  wire logic                i_core_clk,
    input  wire logic                i_sys_rst,
    // Reset pins
    input  wire logic                i_external_reset_pin_n,
    input  wire logic                i_test_port_reset_n,
    output logic                     o_reset_pin_pullup_en,
    // USB device controller events
    input  wire logic                i_usb_bus_reset,
    input  wire logic                i_usb_out_acked,
    output logic                     o_usb_disconnect,
    // Configuration memory loader
    input  wire logic                i_cfg_mem_present,
    input  wire logic                i_cfg_load_done,
    output logic                     o_cfg_load_req,
    output logic                     o_cfg_load_mac_only,
    // Domain resets and PHY
    output rst_domains_t             o_rst,
    output logic                     o_phy_powerdown,
    output logic                     o_ready,
    // Strap pins
    input  wire logic [STRAP_W-1:0]  i_strap_in,
    input  wire logic [STRAP_W-1:0]  i_strap_func_out,
    output logic      [STRAP_W-1:0]  o_strap_out,
    output logic      [STRAP_W-1:0]  o_strap_oe,
    output logic      [STRAP_W-1:0]  o_strap_val,
    // Register port
    input  wire reg_req_t            i_bus,
    output logic      [DATA_W-1:0]   o_rdata
);

    // True when a counter has reached its last cycle
    function automatic logic count_done(input logic [CNT_W-1:0] c, input int unsigned lim);
        count_done = (c >= CNT_W'(lim - 1));
    endfunction

    // True when a bus address selects the given register
    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        addr_is = (a == ofs);
    endfunction

    seq_state_t                state_reg;
    logic [CNT_W-1:0]          cnt_reg;
    logic                      load_full_reg;
    logic [1:0]                pin_sync_reg;
    logic [1:0]                tst_sync_reg;
    logic [STRAP_W-1:0]        strap_s1_reg;
    logic [STRAP_W-1:0]        strap_s2_reg;
    logic [FLD_W-1:0]          usr_cfg_reg;
    logic [FLD_W-1:0]          not_affected_by_soft_reset_cfg_reg;
    logic                      pin_n;
    logic                      wr_hw;
    logic                      wr_pmt;
    logic                      soft_wr;
    logic                      lite_wr;
    logic                      in_hw_rst;
    logic                      in_core_rst;
    logic                      seq_end;
    logic [2:0]                float_age_reg;
    logic                      straps_settled;

    // Two-flop synchronisers for pins
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pin_sync_reg <= 2'h3;
            tst_sync_reg <= 2'h0;
            strap_s1_reg <= '0;
            strap_s2_reg <= '0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[0], i_external_reset_pin_n};
            tst_sync_reg <= {tst_sync_reg[0], i_test_port_reset_n};
            strap_s1_reg <= i_strap_in;
            strap_s2_reg <= strap_s1_reg;
        end
    end

    // Hardware reset history: straps floated through oe flop and both sync flops
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            float_age_reg <= '1;
        end else begin
            float_age_reg <= {float_age_reg[1:0], in_hw_rst}; // R19
        end
    end

    // Decode and state helpers
    assign pin_n       = pin_sync_reg[1];
    assign wr_hw       = i_bus.wr && addr_is(i_bus.addr, OFS_HARDWARE_CONFIG_REG);
    assign wr_pmt      = i_bus.wr && addr_is(i_bus.addr, OFS_POWER_MGMT_CONTROL_REG);
    assign soft_wr     = wr_hw && i_bus.wdata[BIT_SOFT];
    assign lite_wr     = wr_hw && i_bus.wdata[BIT_LITE] && !i_bus.wdata[BIT_SOFT];
    assign in_hw_rst   = (state_reg == ST_POR) || (state_reg == ST_PIN);
    assign in_core_rst = in_hw_rst || (state_reg == ST_SOFT) || (state_reg == ST_LITE)
                         || (state_reg == ST_USB);
    assign seq_end     = (state_reg == ST_USB) && count_done(cnt_reg, USBR_CYCLES);
    assign straps_settled = &float_age_reg;

    // Reset sequencer
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_reg <= ST_POR;
            cnt_reg   <= '0;
        end else if (!pin_n) begin
            state_reg <= ST_PIN; // R04
            cnt_reg   <= '0;
        end else begin
            case (state_reg)
                ST_POR: begin
                    if (count_done(cnt_reg, POR_CYCLES) && straps_settled) begin // R01
                        state_reg <= ST_USB; // R15
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                ST_PIN: begin
                    // Short pin pulses wait until the straps have settled
                    if (straps_settled) begin // R19
                        state_reg <= ST_USB; // R15
                        cnt_reg   <= '0;
                    end
                end
                ST_SOFT_ACK: begin
                    // Let the data stage ack go out first
                    if (i_usb_out_acked || count_done(cnt_reg, ACK_WAIT)) begin // R14
                        state_reg <= ST_SOFT;
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                ST_SOFT: begin
                    if (count_done(cnt_reg, SOFT_CYCLES)) begin // R11
                        state_reg <= ST_USB; // R15
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                ST_LITE: begin
                    if (count_done(cnt_reg, LITE_CYCLES)) begin
                        state_reg <= ST_READY; // R09
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                ST_USB: begin
                    if (seq_end) begin
                        state_reg <= ST_LOAD;
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                ST_LOAD: begin
                    if (i_usb_bus_reset) begin
                        state_reg <= ST_USB;
                        cnt_reg   <= '0;
                    end else if (i_cfg_load_done || !i_cfg_mem_present) begin
                        state_reg <= ST_READY; // R16
                    end
                end
                ST_READY: begin
                    if (i_usb_bus_reset) begin
                        state_reg <= ST_USB;
                        cnt_reg   <= '0;
                    end else if (soft_wr) begin
                        state_reg <= ST_SOFT_ACK;
                        cnt_reg   <= '0;
                    end else if (lite_wr) begin
                        state_reg <= ST_LITE; // R08
                        cnt_reg   <= '0;
                    end
                end
                default: begin
                    state_reg <= ST_POR;
                    cnt_reg   <= '0;
                end
            endcase
        end
    end

    // Kind of memory load for the coming load stage
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            load_full_reg <= 1'b1; // R02
        end else if (in_hw_rst || (state_reg == ST_SOFT)) begin
            load_full_reg <= 1'b1; // R13
        end else if (i_usb_bus_reset && ((state_reg == ST_READY) || (state_reg == ST_LOAD))) begin
            load_full_reg <= 1'b0; // R17
        end
    end

    // Memory load request, one pulse per load stage
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_cfg_load_req      <= 1'b0;
            o_cfg_load_mac_only <= 1'b0;
        end else begin
            o_cfg_load_req <= seq_end && pin_n; // R02 R13 R17
            if (seq_end) begin
                o_cfg_load_mac_only <= !load_full_reg; // R09 R17
            end
        end
    end

    // Domain resets, all released on a core clock edge
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_rst <= '{pll: 1'b1, usb_ctrl: 1'b1, chip_core: 1'b1, test_port: 1'b1};
        end else begin
            o_rst.pll       <= in_hw_rst; // R08 R22
            o_rst.usb_ctrl  <= in_hw_rst || (state_reg == ST_SOFT); // R08 R15
            o_rst.chip_core <= in_core_rst; // R15 R22
            o_rst.test_port <= !tst_sync_reg[1]; // R18
        end
    end

    // USB disconnect after soft reset ack, up to the load stage
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_usb_disconnect <= 1'b1;
        end else if (in_hw_rst || (state_reg == ST_SOFT)) begin
            o_usb_disconnect <= 1'b1; // R14
        end else if (seq_end) begin
            o_usb_disconnect <= 1'b0;
        end
    end

    // PHY power-down; hardware set wins over software clear
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_phy_powerdown <= 1'b1; // R03
        end else if (in_hw_rst || (state_reg == ST_SOFT) || (state_reg == ST_USB)) begin
            o_phy_powerdown <= 1'b1; // R07 R13 R17
        end else if (wr_pmt && (state_reg == ST_READY)) begin
            o_phy_powerdown <= i_bus.wdata[BIT_PHY_PD];
        end
    end

    // Ready flag
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_ready <= 1'b0;
        end else begin
            o_ready <= (state_reg == ST_READY) && pin_n && !i_usb_bus_reset; // R05 R16
        end
    end

    // Software configuration fields
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || in_hw_rst) begin
            usr_cfg_reg  <= USR_RST;
            not_affected_by_soft_reset_cfg_reg <= NOT_AFFECTED_BY_SOFT_RESET_RST;
        end else if (in_core_rst) begin
            usr_cfg_reg <= USR_RST; // R12
        end else if (wr_hw && (state_reg == ST_READY)) begin
            usr_cfg_reg  <= i_bus.wdata[USR_LSB +: FLD_W];
            not_affected_by_soft_reset_cfg_reg <= i_bus.wdata[NOT_AFFECTED_BY_SOFT_RESET_LSB +: FLD_W];
        end
    end

    // Strap pins: released in hardware reset, latched at its end
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_strap_oe  <= '0;
            o_strap_out <= '0;
            o_strap_val <= '0;
        end else begin
            o_strap_oe  <= in_hw_rst ? '0 : '1; // R19 R21
            o_strap_out <= i_strap_func_out;
            if (in_hw_rst && pin_n && straps_settled && (state_reg == ST_PIN
                || count_done(cnt_reg, POR_CYCLES))) begin
                o_strap_val <= strap_s2_reg; // R19 R20
            end
        end
    end

    // Weak pull-up on the reset pin, always on
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_reset_pin_pullup_en <= 1'b1;
        end else begin
            o_reset_pin_pullup_en <= 1'b1; // R06
        end
    end

    // Register contents as seen by a read of one address; unmapped reads 0
    function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] w;
        w = '0;
        if (addr_is(a, OFS_HARDWARE_CONFIG_REG)) begin
            w[BIT_SOFT] = (state_reg == ST_SOFT_ACK) || (state_reg == ST_SOFT); // R11
            w[BIT_LITE] = (state_reg == ST_LITE);
            w[USR_LSB +: FLD_W]  = usr_cfg_reg;
            w[NOT_AFFECTED_BY_SOFT_RESET_LSB +: FLD_W] = not_affected_by_soft_reset_cfg_reg;
        end else if (addr_is(a, OFS_POWER_MGMT_CONTROL_REG)) begin
            w[BIT_READY]  = o_ready; // R05
            w[BIT_PHY_PD] = o_phy_powerdown;
        end else if (addr_is(a, OFS_STRAP)) begin
            w = DATA_W'(o_strap_val);
        end
        read_word = w;
    endfunction

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !i_bus.rd) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= read_word(i_bus.addr);
        end
    end

endmodule

`default_nettype wire

// ===== bench/chip_reset_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module chip_reset_assertions
    import chip_reset_pkg::*;
#(
    parameter int unsigned STRAP_W = 4
) (
    // Clock and reset
    input wire logic               i_core_clk,
    input wire logic               i_sys_rst,
    // Watched inputs
    input wire logic               i_external_reset_pin_n,
    input wire logic               i_test_port_reset_n,
    input wire logic               i_usb_bus_reset,
    // Watched outputs
    input wire logic               o_reset_pin_pullup_en,
    input wire logic               o_cfg_load_req,
    input wire logic               o_cfg_load_mac_only,
    input wire rst_domains_t       o_rst,
    input wire logic               o_phy_powerdown,
    input wire logic               o_ready,
    input wire logic [STRAP_W-1:0] o_strap_oe,
    input wire logic [STRAP_W-1:0] o_strap_val
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    a_pullup_held: assert property (o_reset_pin_pullup_en)
        else $error("reset pin pull-up dropped");
    a_load_pulse: assert property (o_cfg_load_req |=> !o_cfg_load_req)
        else $error("load request longer than one cycle");
    a_ready_waits: assert property (o_cfg_load_req |-> !o_ready)
        else $error("ready high while load requested");
    a_pin_resets: assert property (!i_external_reset_pin_n [*5] |->
        o_rst.pll && o_rst.chip_core && !o_ready && o_phy_powerdown)
        else $error("pin low without full reset");
    a_strap_float: assert property (!i_external_reset_pin_n [*5] |-> o_strap_oe == '0)
        else $error("strap driven during pin reset");
    a_test_reset: assert property ($fell(i_test_port_reset_n) |-> ##[1:4] o_rst.test_port)
        else $error("test port reset missing");
    a_strap_hold: assert property (!o_rst.pll [*4] |-> $stable(o_strap_val))
        else $error("strap value moved outside reset");
    a_usb_mac: assert property ($rose(i_usb_bus_reset) && o_ready |->
        ##[1:40] (o_cfg_load_req && o_cfg_load_mac_only))
        else $error("usb reset without address-only load");
    a_usb_unready: assert property ($rose(i_usb_bus_reset) && o_ready |->
        ##2 (!o_ready && o_rst.chip_core))
        else $error("usb reset left core running");
endmodule

bind chip_reset_and_strap_control chip_reset_assertions #(.STRAP_W(STRAP_W)) u_chk (
    .i_core_clk, .i_sys_rst, .i_external_reset_pin_n, .i_test_port_reset_n,
    .i_usb_bus_reset, .o_reset_pin_pullup_en, .o_cfg_load_req, .o_cfg_load_mac_only,
    .o_rst, .o_phy_powerdown, .o_ready, .o_strap_oe, .o_strap_val
);
`default_nettype wire

// ===== bench/board_usb_model.sv
`timescale 1ns/10ps
`default_nettype none
module board_usb_model (
    // Clock
    input  wire logic       i_clk,
    // Requests
    input  wire logic       i_load_req,
    input  wire logic       i_ack_req,
    input  wire logic [7:0] i_delay,
    // Strap pins
    input  wire logic [3:0] i_pull,
    input  wire logic [3:0] i_strap_oe,
    input  wire logic [3:0] i_strap_out,
    // Answers
    output logic            o_load_done,
    output logic            o_out_acked,
    output wire logic [3:0] o_pins
);
    int ld_cnt = 0;
    int ak_cnt = 0;
    // Board only pulls undriven straps, never drives them
    assign o_pins = (i_strap_oe & i_strap_out) | (~i_strap_oe & i_pull);
    // Memory loader and host OUT ack, both after a set delay
    always @(posedge i_clk) begin
        o_load_done <= (ld_cnt == 1);
        o_out_acked <= (ak_cnt == 1);
        ld_cnt <= i_load_req ? i_delay + 1 : (ld_cnt > 0 ? ld_cnt - 1 : 0);
        ak_cnt <= i_ack_req ? i_delay + 1 : (ak_cnt > 0 ? ak_cnt - 1 : 0);
    end
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import chip_reset_pkg::*;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         pin_n = 1'b1;
    logic         trst_n = 1'b1;
    logic         mem = 1'b1;
    logic         usb_rst = 1'b0;
    logic         ack_req = 1'b0;
    logic [3:0]   pull = 4'h5;
    logic [3:0]   pins, sout, soe, sval;
    reg_req_t     bus = '0;
    rst_domains_t dom;
    logic         acked, ld_done, pu, disc, ld_req, mac, pd, rdy, last_mac;
    logic [31:0]  rdata;
    int           n_fail = 0;
    int           comparisons = 0;
    int           n_loads = 0;
    int           k;

    chip_reset_and_strap_control #(.POR_CYCLES(50), .SOFT_CYCLES(10)) dut (
        .i_core_clk(clk), .i_sys_rst(rst), .i_external_reset_pin_n(pin_n),
        .i_test_port_reset_n(trst_n), .o_reset_pin_pullup_en(pu),
        .i_usb_bus_reset(usb_rst), .i_usb_out_acked(acked), .o_usb_disconnect(disc),
        .i_cfg_mem_present(mem), .i_cfg_load_done(ld_done), .o_cfg_load_req(ld_req),
        .o_cfg_load_mac_only(mac), .o_rst(dom), .o_phy_powerdown(pd), .o_ready(rdy),
        .i_strap_in(pins), .i_strap_func_out(4'ha), .o_strap_out(sout),
        .o_strap_oe(soe), .o_strap_val(sval), .i_bus(bus), .o_rdata(rdata));
    board_usb_model far (
        .i_clk(clk), .i_load_req(ld_req), .i_ack_req(ack_req), .i_delay(8'h05),
        .i_pull(pull), .i_strap_oe(soe), .i_strap_out(sout),
        .o_load_done(ld_done), .o_out_acked(acked), .o_pins(pins));

    // Clock and load bookkeeping
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) if (ld_req === 1'b1) begin
        n_loads++;
        last_mac <= mac;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= {2'b10, a, d};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus <= {2'b01, a, 32'h0};
        @(posedge clk);
        bus <= '0;
        #1 check(rdata, exp);
    endtask
    task automatic wait_ready;
        cyc(4);
        for (int i = 0; i < 3000 && rdy !== 1'b1; i++) cyc(1);
        check(rdy, 1'b1);
    endtask
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        check(pd, 1'b1);
        wait_ready();
        rd(8'h04, 32'h3);
        rd(8'h08, 32'h5);
        rd(8'h0c, 32'h0);
        check(last_mac, 1'b0);
        check({soe, sout}, 8'hfa);
        $display("power-on test done");
        wr(8'h00, 32'h00abcd00);
        wr(8'h04, 32'h0);
        rd(8'h04, 32'h1);
        k = n_loads;
        wr(8'h00, 32'h00abcd02);
        cyc(3);
        check({dom.pll, dom.usb_ctrl, dom.chip_core, disc}, 4'h2);
        wait_ready();
        check(32'(n_loads), 32'(k));
        check({disc, dom.usb_ctrl}, 2'h0);
        rd(8'h00, 32'h00ab0000);
        $display("lite test done");
        wr(8'h00, 32'h00abcd01);
        rd(8'h00, 32'h00abcd01);
        check(disc, 1'b0);
        @(posedge clk);
        ack_req <= 1'b1;
        @(posedge clk);
        ack_req <= 1'b0;
        cyc(10);
        check(disc, 1'b1);
        wait_ready();
        rd(8'h00, 32'h00ab0000);
        rd(8'h04, 32'h3);
        check(last_mac, 1'b0);
        check(32'(n_loads), 32'(k + 1));
        rd(8'h08, 32'h5);
        $display("soft test done");
        @(posedge clk);
        usb_rst <= 1'b1;
        @(posedge clk);
        usb_rst <= 1'b0;
        cyc(3);
        check(rdy, 1'b0);
        wait_ready();
        check(last_mac, 1'b1);
        rd(8'h04, 32'h3);
        rd(8'h08, 32'h5);
        $display("usb reset test done");
        @(posedge clk);
        mem <= 1'b0;
        usb_rst <= 1'b1;
        @(posedge clk);
        usb_rst <= 1'b0;
        cyc(20);
        check(rdy, 1'b1);
        @(posedge clk);
        mem <= 1'b1;
        $display("no memory test done");
        @(posedge clk);
        pull <= 4'h9;
        pin_n <= 1'b0;
        cyc(8);
        check({rdy, pd, dom.pll, soe}, 7'h30);
        @(posedge clk);
        pin_n <= 1'b1;
        wait_ready();
        rd(8'h08, 32'h9);
        rd(8'h00, 32'h0);
        check(last_mac, 1'b0);
        $display("pin reset test done");
        @(posedge clk);
        trst_n <= 1'b0;
        cyc(5);
        check({dom.test_port, dom.chip_core, rdy}, 3'b101);
        @(posedge clk);
        trst_n <= 1'b1;
        cyc(5);
        check(dom.test_port, 1'b0);
        $display("test reset test done");
        conclude();
    end
endmodule
`default_nettype wire
